/* File: pkg/ssc_pkg.sv */
// constants, types and register map of the system setup command handler
// Contract
// - dialect query answers SCPI or legacy token
// - legacy dialect accepts old command forms too
// - SCPI dialect ignores old command formats
// - factory dialect setting is legacy
// - matching enable value sets password state
// - matching disable value clears password state
// - password query answers one or zero
// - security wipe restores step and limit defaults
// - wipe sets power-up output off, default password
// - compat option selects old bus behaviour
// - clear option makes device clear a reset
// - empty read gives newline or nothing
// - debug option gates diagnostic commands
// - cell 41 saves options, outputs; restored power-up
// - version query answers 2003.0
// - external trigger loads stored trigger settings
// - external source selection stops continuous mode
// - protected command without password logs -203
// - wrong enable password logs -221
package ssc_pkg;
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESP = 8'h08;
    localparam logic [7:0] ADDR_ERROR = 8'h0c;
    localparam logic [7:0] ADDR_OUTPUT = 8'h10;
    localparam logic [7:0] ADDR_TRIG = 8'h14;
    localparam logic [7:0] ADDR_PROT = 8'h18;
    localparam logic [1:0] ADDR_STEP_HI = 2'h1;
    localparam int STEP_N = 16;
    localparam int FULL_SCALE = 4095;
    localparam int CUR_PCT_X100 = 128;
    localparam int PROT_PCT = 10;
    localparam logic [11:0] DEF_CUR = 12'(FULL_SCALE * CUR_PCT_X100 / 10000);
    localparam logic [12:0] PROT_MAX = 13'(FULL_SCALE + FULL_SCALE * PROT_PCT / 100);
    localparam logic [15:0] PASS_DEFAULT = 16'h0000;
    localparam logic [15:0] SAVE_CELL = 16'h0029;
    // two's complement of -203, -221, -113
    localparam logic [15:0] ERR_PROTECTED = 16'hff35;
    localparam logic [15:0] ERR_CONFLICT = 16'hff23;
    localparam logic [15:0] ERR_UNDEF = 16'hff8f;
    localparam logic [31:0] RESP_SCPI = 32'h53435049;
    localparam logic [31:0] RESP_LEGACY = 32'h434f4d50;
    localparam logic [31:0] RESP_NEWLINE = 32'h0000000a;
    localparam logic [15:0] VERS_YEAR = 16'h07d3;
    localparam logic [7:0] VERS_SEP = 8'h2e;
    localparam logic [7:0] VERS_REV = 8'h00;
    localparam int ST_LEGACY = 0;
    localparam int ST_PASS = 1;
    localparam int ST_OPTS = 2;
    localparam int ST_TRIG_EXT = 6;
    localparam int ST_CONT = 7;
    localparam int ST_ARMED = 8;
    localparam int ST_RESP_VALID = 9;
    localparam int ST_DEV_ERR = 19;
    localparam int ST_EXEC_ERR = 20;
    localparam int ST_CMD_ERR = 21;
    typedef enum logic [7:0] {
        OP_LANG_QUERY = 8'h01,
        OP_LANG_LEGACY = 8'h02,
        OP_LANG_SCPI = 8'h03,
        OP_PASS_EN = 8'h04,
        OP_PASS_DIS = 8'h05,
        OP_PASS_QUERY = 8'h06,
        OP_SEC_IMM = 8'h07,
        OP_SET_OPTION = 8'h08,
        OP_VERS_QUERY = 8'h09,
        OP_TRIG_EXT = 8'h0a,
        OP_TRIG_BUS = 8'h0b,
        OP_INIT_CONT = 8'h0c,
        OP_INIT_IMM = 8'h0d,
        OP_SAVE = 8'h0e,
        OP_LIST_TIME = 8'h0f,
        OP_DEBUG_VDAC = 8'h10,
        OP_RESET = 8'h11,
        OP_VOLT = 8'h12,
        OP_CURR = 8'h13,
        OP_OUTP = 8'h14,
        OP_VOLT_TRIG = 8'h15,
        OP_CURR_TRIG = 8'h16
    } ssc_op_e;
    typedef enum logic [2:0] {
        COMPAT_OPTION_OFF = 3'h0,
        COMPAT_OPTION_ON = 3'h1,
        CLEAR_RESETS_OFF = 3'h2,
        CLEAR_RESETS_ON = 3'h3,
        EMPTY_READ_NEWLINE_OFF = 3'h4,
        EMPTY_READ_NEWLINE_ON = 3'h5,
        DEBUG_COMMANDS_OFF = 3'h6,
        DEBUG_COMMANDS_ON = 3'h7
    } ssc_opt_e;
    typedef struct packed {
        logic debug;
        logic newline;
        logic clr_rst;
        logic compat;
    } ssc_opts_s;
    typedef struct packed {
        logic on;
        logic [11:0] v;
        logic [11:0] i;
    } ssc_out_s;
    typedef struct packed {
        logic [11:0] v;
        logic [11:0] i;
        logic [3:0] dwell;
        logic [3:0] nxt;
    } ssc_step_s;
    localparam ssc_opts_s OPTS_DEFAULT = 4'h0;
    localparam ssc_out_s OUT_OFF = 25'h0;
endpackage

/* File: logic/ssc_system_setup.sv */
// system setup command handler with avalon-mm register slave
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ssc_system_setup (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_NV_RST,
    input wire logic [7:0] I_ADDRESS,
    input wire logic I_READ,
    input wire logic I_WRITE,
    input wire logic [31:0] I_WRITEDATA,
    input wire logic [3:0] I_BYTEENABLE,
    output var logic [31:0] O_READDATA,
    output var logic O_WAITREQUEST,
    input wire logic I_TRIG_N,
    input wire logic I_DEV_CLEAR,
    output var logic O_OUT_ON,
    output var logic [11:0] O_SET_V,
    output var logic [11:0] O_SET_I,
    output var logic O_COMPAT
);
    ssc_pkg::ssc_op_e op;
    logic [15:0] arg;
    logic known, legacy_only, debug_only, protect;
    logic cmd_go, rd_pop, st_wr, reject_undef, reject_prot, bad_pass, accept;
    logic legacy, pass_en, restore, trig_ext, cont, armed, resp_valid;
    logic exec_err, cmd_err, do_rst, fire;
    logic [31:0] resp;
    logic [15:0] err_code, pass_stored;
    ssc_pkg::ssc_opts_s opts, nv_opts;
    ssc_pkg::ssc_out_s outs, nv_out;
    logic [11:0] trig_v, trig_i;
    logic [12:0] prot_v, prot_i;
    ssc_pkg::ssc_step_s steps [ssc_pkg::STEP_N];
    logic tr_s1, tr_s2, tr_s3, dc_s1, dc_s2, dc_s3;
    logic trig_edge, dc_edge;

    function automatic logic hit(input ssc_pkg::ssc_op_e o);
        return accept && (op == o);
    endfunction

    assign cmd_go = I_WRITE && !O_WAITREQUEST
        && (I_ADDRESS == ssc_pkg::ADDR_CMD) && (I_BYTEENABLE == 4'hf);
    assign st_wr = I_WRITE && !O_WAITREQUEST
        && (I_ADDRESS == ssc_pkg::ADDR_STATUS) && I_BYTEENABLE[2];
    assign rd_pop = I_READ && !O_WAITREQUEST && (I_ADDRESS == ssc_pkg::ADDR_RESP);

    always_comb begin
        op = ssc_pkg::ssc_op_e'(I_WRITEDATA[7:0]);
        arg = I_WRITEDATA[31:16];
        known = 1'b1;
        legacy_only = 1'b0;
        debug_only = 1'b0;
        protect = 1'b0;
        unique case (op)
            ssc_pkg::OP_LIST_TIME: legacy_only = 1'b1;
            ssc_pkg::OP_DEBUG_VDAC: debug_only = 1'b1;
            ssc_pkg::OP_SEC_IMM: protect = 1'b1;
            ssc_pkg::OP_SAVE: protect = (arg == ssc_pkg::SAVE_CELL);
            ssc_pkg::OP_LANG_QUERY, ssc_pkg::OP_LANG_LEGACY,
            ssc_pkg::OP_LANG_SCPI, ssc_pkg::OP_PASS_EN, ssc_pkg::OP_PASS_DIS,
            ssc_pkg::OP_PASS_QUERY, ssc_pkg::OP_SET_OPTION,
            ssc_pkg::OP_VERS_QUERY, ssc_pkg::OP_TRIG_EXT, ssc_pkg::OP_TRIG_BUS,
            ssc_pkg::OP_INIT_CONT, ssc_pkg::OP_INIT_IMM, ssc_pkg::OP_RESET,
            ssc_pkg::OP_VOLT, ssc_pkg::OP_CURR, ssc_pkg::OP_OUTP,
            ssc_pkg::OP_VOLT_TRIG, ssc_pkg::OP_CURR_TRIG: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    // legacy forms drop out under SCPI before touching any setting
    assign reject_undef = cmd_go && (!known || (legacy_only && !legacy)
        || (debug_only && !opts.debug));
    // the host is expected to unlock first; a locked request is refused
    assign reject_prot = cmd_go && !reject_undef && protect && !pass_en;
    assign bad_pass = cmd_go && (op == ssc_pkg::OP_PASS_EN)
        && (arg != pass_stored);
    assign accept = cmd_go && !reject_undef && !reject_prot;
    assign trig_edge = tr_s3 && !tr_s2;
    assign dc_edge = dc_s2 && !dc_s3;
    assign do_rst = hit(ssc_pkg::OP_RESET) || (dc_edge && opts.clr_rst);
    assign fire = trig_edge && trig_ext && (armed || cont);

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            {tr_s1, tr_s2, tr_s3} <= 3'h7;
            {dc_s1, dc_s2, dc_s3} <= 3'h0;
        end else begin
            {tr_s1, tr_s2, tr_s3} <= {I_TRIG_N, tr_s1, tr_s2};
            {dc_s1, dc_s2, dc_s3} <= {I_DEV_CLEAR, dc_s1, dc_s2};
        end
    end

    // one wait state per access keeps read data a flop output
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_WAITREQUEST <= 1'b1;
            O_READDATA <= 32'h0;
        end else begin
            O_WAITREQUEST <= !((I_READ || I_WRITE) && O_WAITREQUEST);
            if (I_READ && O_WAITREQUEST) begin
                if (I_ADDRESS[7:6] == ssc_pkg::ADDR_STEP_HI) begin
                    O_READDATA <= steps[I_ADDRESS[5:2]];
                end else begin
                    unique case (I_ADDRESS)
                        ssc_pkg::ADDR_STATUS: O_READDATA <= {10'h0, cmd_err,
                            exec_err, 10'h0, resp_valid, armed, cont,
                            trig_ext, opts, pass_en, legacy};
                        ssc_pkg::ADDR_RESP: O_READDATA <= resp_valid ? resp
                            : (opts.newline ? ssc_pkg::RESP_NEWLINE : 32'h0);
                        ssc_pkg::ADDR_ERROR: O_READDATA <= {16'h0, err_code};
                        ssc_pkg::ADDR_OUTPUT: O_READDATA <= {outs.on, 3'h0,
                            outs.v, 4'h0, outs.i};
                        ssc_pkg::ADDR_TRIG: O_READDATA <= {4'h0, trig_v, 4'h0, trig_i};
                        ssc_pkg::ADDR_PROT: O_READDATA <= {3'h0, prot_v, 3'h0, prot_i};
                        default: O_READDATA <= 32'h0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            legacy <= 1'b1;
        end else if (hit(ssc_pkg::OP_LANG_LEGACY)) begin
            legacy <= 1'b1;
        end else if (hit(ssc_pkg::OP_LANG_SCPI)) begin
            legacy <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pass_en <= 1'b0;
        end else if (hit(ssc_pkg::OP_PASS_EN) && arg == pass_stored) begin
            pass_en <= 1'b1;
        end else if (hit(ssc_pkg::OP_PASS_DIS) && arg == pass_stored) begin
            pass_en <= 1'b0;
        end
    end

    // non-volatile image survives I_RST; only I_NV_RST builds it afresh
    always_ff @(posedge I_CLK or posedge I_NV_RST) begin
        if (I_NV_RST) begin
            nv_opts <= ssc_pkg::OPTS_DEFAULT;
            nv_out <= ssc_pkg::OUT_OFF;
            pass_stored <= ssc_pkg::PASS_DEFAULT;
        end else if (hit(ssc_pkg::OP_SEC_IMM)) begin
            nv_out <= ssc_pkg::OUT_OFF;
            pass_stored <= ssc_pkg::PASS_DEFAULT;
        end else if (hit(ssc_pkg::OP_SAVE) && arg == ssc_pkg::SAVE_CELL) begin
            nv_opts <= opts;
            nv_out <= outs;
        end
    end

    always_ff @(posedge I_CLK or posedge I_NV_RST) begin
        if (I_NV_RST) begin
            prot_v <= ssc_pkg::PROT_MAX;
            prot_i <= ssc_pkg::PROT_MAX;
            for (int k = 0; k < ssc_pkg::STEP_N; k++) begin
                steps[k] <= '{12'h0, ssc_pkg::DEF_CUR, 4'h0, 4'h0};
            end
        end else if (hit(ssc_pkg::OP_SEC_IMM)) begin
            prot_v <= ssc_pkg::PROT_MAX;
            prot_i <= ssc_pkg::PROT_MAX;
            for (int k = 0; k < ssc_pkg::STEP_N; k++) begin
                steps[k] <= '{12'h0, ssc_pkg::DEF_CUR, 4'h0, 4'h0};
            end
        end else if (hit(ssc_pkg::OP_LIST_TIME)) begin
            steps[arg[15:12]].dwell <= arg[3:0];
        end
    end

    // power-up restore runs on the first edge after I_RST is released
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            restore <= 1'b1;
            opts <= ssc_pkg::OPTS_DEFAULT;
        end else begin
            restore <= 1'b0;
            if (restore) begin
                opts <= nv_opts;
            end else if (hit(ssc_pkg::OP_SET_OPTION)) begin
                unique case (ssc_pkg::ssc_opt_e'(arg[2:0]))
                    ssc_pkg::COMPAT_OPTION_OFF: opts.compat <= 1'b0;
                    ssc_pkg::COMPAT_OPTION_ON: opts.compat <= 1'b1;
                    ssc_pkg::CLEAR_RESETS_OFF: opts.clr_rst <= 1'b0;
                    ssc_pkg::CLEAR_RESETS_ON: opts.clr_rst <= 1'b1;
                    ssc_pkg::EMPTY_READ_NEWLINE_OFF: opts.newline <= 1'b0;
                    ssc_pkg::EMPTY_READ_NEWLINE_ON: opts.newline <= 1'b1;
                    ssc_pkg::DEBUG_COMMANDS_OFF: opts.debug <= 1'b0;
                    ssc_pkg::DEBUG_COMMANDS_ON: opts.debug <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            outs <= ssc_pkg::OUT_OFF;
            trig_v <= 12'h0;
            trig_i <= 12'h0;
        end else begin
            if (restore) begin
                outs <= nv_out;
            end else if (do_rst) begin
                outs <= ssc_pkg::OUT_OFF;
            end else if (fire) begin
                outs.v <= trig_v;
                outs.i <= trig_i;
            end else if (hit(ssc_pkg::OP_VOLT)) begin
                outs.v <= arg[11:0];
            end else if (hit(ssc_pkg::OP_CURR)) begin
                outs.i <= arg[11:0];
            end else if (hit(ssc_pkg::OP_OUTP)) begin
                outs.on <= arg[0];
            end
            if (hit(ssc_pkg::OP_VOLT_TRIG)) begin
                trig_v <= arg[11:0];
            end
            if (hit(ssc_pkg::OP_CURR_TRIG)) begin
                trig_i <= arg[11:0];
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            trig_ext <= 1'b0;
            cont <= 1'b0;
            armed <= 1'b0;
        end else if (do_rst) begin
            trig_ext <= 1'b0;
            cont <= 1'b0;
            armed <= 1'b0;
        end else begin
            if (hit(ssc_pkg::OP_TRIG_EXT)) begin
                trig_ext <= 1'b1;
                cont <= 1'b0;
            end else if (hit(ssc_pkg::OP_TRIG_BUS)) begin
                trig_ext <= 1'b0;
            end else if (hit(ssc_pkg::OP_INIT_CONT)) begin
                cont <= arg[0];
            end
            if (hit(ssc_pkg::OP_INIT_IMM)) begin
                armed <= 1'b1;
            end else if (fire) begin
                armed <= 1'b0;
            end
        end
    end

    // single-word output buffer; a new query overwrites an unread answer
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            resp <= 32'h0;
            resp_valid <= 1'b0;
        end else if (accept && (op == ssc_pkg::OP_LANG_QUERY
            || op == ssc_pkg::OP_PASS_QUERY || op == ssc_pkg::OP_VERS_QUERY
            || op == ssc_pkg::OP_DEBUG_VDAC)) begin
            resp_valid <= 1'b1;
            unique case (op)
                ssc_pkg::OP_LANG_QUERY: resp <= legacy ? ssc_pkg::RESP_LEGACY
                    : ssc_pkg::RESP_SCPI;
                ssc_pkg::OP_PASS_QUERY: resp <= {31'h0, pass_en};
                ssc_pkg::OP_VERS_QUERY: resp <= {ssc_pkg::VERS_YEAR,
                    ssc_pkg::VERS_SEP, ssc_pkg::VERS_REV};
                default: resp <= {20'h0, outs.v};
            endcase
        end else if (rd_pop || dc_edge) begin
            resp_valid <= 1'b0;
        end
    end

    // new error wins over a same-cycle write-one-to-clear
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            err_code <= 16'h0;
            exec_err <= 1'b0;
            cmd_err <= 1'b0;
        end else begin
            if (reject_undef) begin
                err_code <= ssc_pkg::ERR_UNDEF;
            end else if (reject_prot) begin
                err_code <= ssc_pkg::ERR_PROTECTED;
            end else if (bad_pass) begin
                err_code <= ssc_pkg::ERR_CONFLICT;
            end
            cmd_err <= reject_undef || (cmd_err
                && !(st_wr && I_WRITEDATA[ssc_pkg::ST_CMD_ERR]));
            exec_err <= reject_prot || bad_pass || (exec_err
                && !(st_wr && I_WRITEDATA[ssc_pkg::ST_EXEC_ERR]));
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_OUT_ON <= 1'b0;
            O_SET_V <= 12'h0;
            O_SET_I <= 12'h0;
            O_COMPAT <= 1'b0;
        end else begin
            O_OUT_ON <= outs.on;
            O_SET_V <= outs.v;
            O_SET_I <= outs.i;
            O_COMPAT <= opts.compat;
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST || I_NV_RST);

    sequence op_seen(ssc_pkg::ssc_op_e o);
        cmd_go && op == o;
    endsequence
    sequence empty_read;
        I_READ && O_WAITREQUEST && I_ADDRESS == ssc_pkg::ADDR_RESP && !resp_valid;
    endsequence

    lang_query_a: assert property (op_seen(ssc_pkg::OP_LANG_QUERY) |=>
        resp == ($past(legacy) ? ssc_pkg::RESP_LEGACY : ssc_pkg::RESP_SCPI))
        else $error("dialect answer wrong");
    legacy_reject_a: assert property (op_seen(ssc_pkg::OP_LIST_TIME)
        ##0 !legacy |=> cmd_err && err_code == ssc_pkg::ERR_UNDEF
        && steps[$past(arg[15:12])] == $past(steps[arg[15:12]]))
        else $error("legacy command not refused");
    legacy_accept_a: assert property (op_seen(ssc_pkg::OP_LIST_TIME)
        ##0 legacy |=> steps[$past(arg[15:12])].dwell == $past(arg[3:0]))
        else $error("legacy command not applied");
    pass_set_a: assert property (op_seen(ssc_pkg::OP_PASS_EN)
        |=> pass_en == ($past(pass_en) || $past(arg) == $past(pass_stored)))
        else $error("password enable wrong");
    pass_clear_a: assert property (op_seen(ssc_pkg::OP_PASS_DIS)
        |=> pass_en == ($past(pass_en) && $past(arg) != $past(pass_stored)))
        else $error("password disable wrong");
    pass_query_a: assert property (op_seen(ssc_pkg::OP_PASS_QUERY)
        |=> resp_valid && resp == {31'h0, $past(pass_en)})
        else $error("password query wrong");
    wipe_steps_a: assert property (op_seen(ssc_pkg::OP_SEC_IMM) ##0 pass_en
        |=> steps[0].i == ssc_pkg::DEF_CUR && steps[0].v == 12'h0
        && prot_v == ssc_pkg::PROT_MAX) else $error("wipe defaults wrong");
    wipe_power_a: assert property (op_seen(ssc_pkg::OP_SEC_IMM) ##0 pass_en
        |=> !nv_out.on && pass_stored == ssc_pkg::PASS_DEFAULT)
        else $error("wipe power-up state wrong");
    protect_a: assert property (cmd_go && protect && !pass_en && known
        |=> exec_err && $stable(nv_out) && $stable(prot_v))
        else $error("protected command not refused");
    bad_pass_a: assert property (op_seen(ssc_pkg::OP_PASS_EN)
        ##0 arg != pass_stored |=> exec_err && err_code == ssc_pkg::ERR_CONFLICT)
        else $error("bad password not logged");
    empty_read_a: assert property (empty_read |=> !O_WAITREQUEST
        && O_READDATA == ($past(opts.newline) ? ssc_pkg::RESP_NEWLINE : 32'h0))
        else $error("empty read answer wrong");
    version_a: assert property (op_seen(ssc_pkg::OP_VERS_QUERY)
        |=> resp == 32'h07d32e00) else $error("version answer wrong");
    ext_load_a: assert property (fire && !do_rst && !restore
        |=> outs.v == $past(trig_v) ##1 O_SET_I == $past(trig_i, 2))
        else $error("trigger load wrong");
    cont_off_a: assert property (op_seen(ssc_pkg::OP_TRIG_EXT)
        ##0 !dc_edge |=> trig_ext && !cont) else $error("continuous mode kept");
    clear_keep_a: assert property (dc_edge && !opts.clr_rst && !cmd_go
        && !fire && !restore |=> outs == $past(outs))
        else $error("device clear changed output");
    save_cell_a: assert property (op_seen(ssc_pkg::OP_SAVE) ##0 pass_en
        ##0 arg == ssc_pkg::SAVE_CELL |=> nv_opts == $past(opts)
        && nv_out == $past(outs)) else $error("save image wrong");
    compat_out_a: assert property ($changed(opts.compat)
        |=> O_COMPAT == $past(opts.compat)) else $error("compat level lags");
endmodule
`default_nettype wire

/* File: testbench/ssc_host_model.sv */
// host model: avalon-mm master issuing command words
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
    input wire logic i_clk,
    input wire logic i_waitrequest,
    input wire logic [31:0] i_readdata,
    output logic [7:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable
);
    initial begin
        {o_address, o_read, o_write, o_writedata} = '0;
        o_byteenable = 4'hf;
    end
    // request held until waitrequest seen low at an edge
    task automatic acc(input logic rd, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk);
        o_address <= a;
        o_read <= rd;
        o_write <= !rd;
        o_writedata <= d;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        q = i_readdata;
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench of the system setup command handler
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst = 1, nvr = 1, trig_n = 1, dclr = 0;
    logic wrq, rd, wr, on, cmp;
    logic [7:0] a;
    logic [3:0] be, k, d;
    logic [11:0] sv, si, v, tv, ti;
    logic [31:0] wd, rdat, q;
    logic [15:0] lf = 16'd26842;
    int miscompares = 0, compares = 0;
    always #20 clk = ~clk;
    ssc_host_model host_u(.i_clk(clk), .i_waitrequest(wrq),
        .i_readdata(rdat), .o_address(a), .o_read(rd), .o_write(wr),
        .o_writedata(wd), .o_byteenable(be));
    // nv image is built once; later resets must leave it alone
    ssc_system_setup dut_u(.I_CLK(clk), .I_RST(rst), .I_NV_RST(nvr),
        .I_ADDRESS(a), .I_READ(rd), .I_WRITE(wr), .I_WRITEDATA(wd),
        .I_BYTEENABLE(be), .O_READDATA(rdat), .O_WAITREQUEST(wrq),
        .I_TRIG_N(trig_n), .I_DEV_CLEAR(dclr), .O_OUT_ON(on),
        .O_SET_V(sv), .O_SET_I(si), .O_COMPAT(cmp));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // factory step word with a chosen dwell
    function automatic logic [31:0] stw(input logic [3:0] dw);
        return {12'h000, ssc_pkg::DEF_CUR, dw, 4'h0};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
        host_u.acc(1'b0, ssc_pkg::ADDR_CMD, {arg, 8'h00, op}, q);
    endtask
    task automatic rdr(input logic [7:0] ad);
        host_u.acc(1'b1, ad, 32'h0, q);
    endtask
    task automatic ask(input logic [7:0] op, input logic [31:0] e);
        cmd(op, 16'h0);
        rdr(ssc_pkg::ADDR_RESP);
        chk("resp", q, e);
    endtask
    // nv image survives: only the live reset is pulsed mid-run
    task automatic rerun;
        @(posedge clk) rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #2000000;
        miscompares++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        nvr <= 1'b0;
        repeat (2) @(posedge clk);
        lf = nx(lf);
        {k, v, d} = {lf[15:12], lf[11:0], lf[3:0] | 4'h1};
        rdr(ssc_pkg::ADDR_STATUS);
        chk("legacy", q[0], 1);
        ask(ssc_pkg::OP_LANG_QUERY, ssc_pkg::RESP_LEGACY);
        cmd(ssc_pkg::OP_LIST_TIME, {k, 8'h00, d});
        rdr({2'h1, k, 2'h0});
        chk("step", q, stw(d));
        cmd(ssc_pkg::OP_LANG_SCPI, 16'h0);
        ask(ssc_pkg::OP_LANG_QUERY, ssc_pkg::RESP_SCPI);
        cmd(ssc_pkg::OP_LIST_TIME, {k, 8'h00, ~d});
        rdr({2'h1, k, 2'h0});
        chk("step", q, stw(d));
        rdr(ssc_pkg::ADDR_ERROR);
        chk("err", q[15:0], ssc_pkg::ERR_UNDEF);
        cmd(ssc_pkg::OP_SEC_IMM, 16'h0);
        rdr(ssc_pkg::ADDR_ERROR);
        chk("err", q[15:0], ssc_pkg::ERR_PROTECTED);
        cmd(ssc_pkg::OP_PASS_EN, ~ssc_pkg::PASS_DEFAULT);
        rdr(ssc_pkg::ADDR_ERROR);
        chk("err", q[15:0], ssc_pkg::ERR_CONFLICT);
        ask(ssc_pkg::OP_PASS_QUERY, 0);
        cmd(ssc_pkg::OP_PASS_EN, ssc_pkg::PASS_DEFAULT);
        ask(ssc_pkg::OP_PASS_QUERY, 1);
        cmd(ssc_pkg::OP_SEC_IMM, 16'h0);
        rdr({2'h1, k, 2'h0});
        chk("step", q, stw(0));
        rdr(ssc_pkg::ADDR_PROT);
        chk("prot", q, {3'h0, ssc_pkg::PROT_MAX, 3'h0, ssc_pkg::PROT_MAX});
        cmd(ssc_pkg::OP_PASS_DIS, ssc_pkg::PASS_DEFAULT);
        ask(ssc_pkg::OP_PASS_QUERY, 0);
        ask(ssc_pkg::OP_VERS_QUERY, 32'h07d32e00);
        for (int o = 0; o < 8; o++) begin
            cmd(ssc_pkg::OP_SET_OPTION, 16'(o));
            rdr(ssc_pkg::ADDR_STATUS);
            chk("opt", q[2 + o / 2], o % 2);
            if (o < 2) chk("compat", cmp, o);
        end
        rdr(ssc_pkg::ADDR_RESP);
        chk("nl", q, ssc_pkg::RESP_NEWLINE);
        cmd(ssc_pkg::OP_VOLT, {4'h0, v});
        ask(ssc_pkg::OP_DEBUG_VDAC, {20'h0, v});
        cmd(ssc_pkg::OP_SET_OPTION, 16'h4);
        cmd(ssc_pkg::OP_SET_OPTION, 16'h6);
        ask(ssc_pkg::OP_DEBUG_VDAC, 0);
        cmd(ssc_pkg::OP_OUTP, 16'h1);
        for (int o = 2; o < 4; o++) begin
            cmd(ssc_pkg::OP_SET_OPTION, 16'(o));
            @(posedge clk) dclr <= 1'b1;
            repeat (4) @(posedge clk);
            dclr <= 1'b0;
            repeat (6) @(posedge clk);
            chk("clr", {on, sv}, o == 2 ? {1'b1, v} : 13'h0);
        end
        lf = nx(lf);
        {tv, ti} = {lf[11:0], ~lf[11:0]};
        cmd(ssc_pkg::OP_VOLT_TRIG, {4'h0, tv});
        cmd(ssc_pkg::OP_CURR_TRIG, {4'h0, ti});
        cmd(ssc_pkg::OP_INIT_CONT, 16'h1);
        cmd(ssc_pkg::OP_TRIG_EXT, 16'h0);
        rdr(ssc_pkg::ADDR_STATUS);
        chk("cont", q[7], 0);
        cmd(ssc_pkg::OP_INIT_IMM, 16'h0);
        @(posedge clk) trig_n <= 1'b0;
        repeat (4) @(posedge clk);
        trig_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk("trig", {sv, si}, {tv, ti});
        cmd(ssc_pkg::OP_PASS_EN, ssc_pkg::PASS_DEFAULT);
        cmd(ssc_pkg::OP_SET_OPTION, 16'h1);
        cmd(ssc_pkg::OP_OUTP, 16'h1);
        cmd(ssc_pkg::OP_SAVE, ssc_pkg::SAVE_CELL);
        rerun;
        chk("restore", {cmp, on}, 2'b11);
        cmd(ssc_pkg::OP_PASS_EN, ssc_pkg::PASS_DEFAULT);
        cmd(ssc_pkg::OP_SEC_IMM, 16'h0);
        rerun;
        chk("wiped", {cmp, on}, 2'b10);
        cmd(ssc_pkg::OP_PASS_EN, ssc_pkg::PASS_DEFAULT);
        ask(ssc_pkg::OP_PASS_QUERY, 1);
        complete_run;
    end
endmodule
`default_nettype wire
